// ### cmc_pkg.sv
// Package of constants for the CAN operating-mode controller.
// How it works
// RL1: After hardware reset the controller sits in Sleep mode.
// RL2: Init and sleep requests are acknowledged only once the mode is entered.
// RL3: Normal mode means init_ack and low_power_ack both read cleared.
// RL4: Normal traffic waits for 11 consecutive recessive receive bits.
// RL5: Clearing init_request leaves Initialization once hardware clears init_ack.
// RL6: Initialization stops transfers and drives the transmit pin recessive high.
// RL7: Entering Initialization leaves configuration registers unchanged.
// RL8: Software should keep unused filter banks inactive.
// RL9: Software writes filters while inactive, scale and mode in Initialization.
// RL10: In Sleep the core clock stops and status bits freeze.
// RL11: An init request made during Sleep is never acknowledged; the code acknowledges it once the sleep request clears and Sleep ends.
// RL12: Sleep ends on software clear or automatic clear on bus activity.
// RL13: Without auto wake-up software clears sleep request on wake-up interrupt.
// RL14: Wake-up interrupt fires on bus activity in Sleep when enabled.
// RL15: Sleep ends after bus synchronisation, then low_power_ack clears.
// RL16: Test mode bits are set in Initialization, effective in Normal.
// RL17: Silent mode receives but sends only recessive bits, never transmits.
// RL18: Silent mode loops dominant core bits back internally.
// RL19: Loop back mode receives its own transmitted frames.
// RL20: Loop back mode ignores acknowledge errors.
// RL21: Loop back feeds transmit to receive, ignores receive pin, shows transmit.
// RL22: Combined mode disconnects receive pin and holds transmit recessive.
// RL23: Sleep bus activity is a dominant level on the synchronised receive pin.
package cmc_pkg;
   localparam int IDLE_BITS = 11;
   localparam logic [3:0] IDLE_CNT_W = 4'd4;
   localparam int CLK_MHZ = 25;
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_STAT = 8'h01;
   localparam logic [7:0] ADDR_DIAG = 8'h02;
   localparam logic [7:0] ADDR_IRQEN = 8'h03;
   localparam int CTRL_INIT = 0;
   localparam int CTRL_SLEEP = 1;
   localparam int CTRL_AWAKE = 2;
   localparam int STAT_INIT_ACK = 0;
   localparam int STAT_LOW_POWER_ACK = 1;
   localparam int STAT_WAKE = 2;
   localparam int STAT_SYNC = 3;
   localparam int DIAG_SILENT = 0;
   localparam int DIAG_LOOP = 1;
   localparam int IRQEN_WAKE = 0;
   localparam logic [7:0] CTRL_RST = 8'h02;
   localparam logic [7:0] DIAG_RST = 8'h00;
   localparam logic [7:0] IRQEN_RST = 8'h00;
   typedef enum logic [1:0] {CMC_SLEEP, CMC_INIT, CMC_SYNC, CMC_NORMAL}
      cmc_mode_e;
endpackage

// ### cmc_idle_det.sv
// Counts consecutive recessive bits to detect bus idle.
`timescale 1ns/1ps
module cmc_idle_det #(
   parameter int IDLE_BITS = 11
) (
   // Clock and reset.
   input wire logic core_clk,
   input wire logic reset,
   input wire logic clkEn,
   // Bit sampling.
   input wire logic bitTick,
   input wire logic rxBit,
   input wire logic clear,
   // Result.
   output logic idle
);
   logic [7:0] cnt_r;

   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         cnt_r <= 8'h00;
      end else if (clkEn) begin
         if (clear || (bitTick && !rxBit)) begin
            cnt_r <= 8'h00;
         end else if (bitTick && cnt_r < 8'(IDLE_BITS)) begin
            cnt_r <= cnt_r + 8'h01;
         end
      end
   end

   assign idle = (cnt_r >= 8'(IDLE_BITS));
endmodule

// ### cmc_mode_ctrl.sv
// Operating-mode controller with test-mode routing of the bus pins.
`timescale 1ns/1ps
module cmc_mode_ctrl (
   // Clock, enable and reset.
   input wire logic core_clk,
   input wire logic reset,
   input wire logic clkEn,
   // Register port.
   input wire logic [7:0] regAddr,
   input wire logic [7:0] regWrData,
   input wire logic regWr,
   input wire logic regRd,
   output logic [7:0] regRdData,
   // Bit timing from the protocol core.
   input wire logic bitTick,
   // Protocol core side.
   input wire logic coreTx,
   input wire logic coreTxStart,
   output logic coreRx,
   output logic coreActive,
   output logic coreIgnoreAckErr,
   output logic coreTxAllowed,
   output logic coreClkRun,
   // Bus pins.
   input wire logic bus_rx_pin,
   output logic bus_tx_pin,
   // Wake-up interrupt request.
   output logic wakeIrq
);
   import cmc_pkg::*;

   cmc_mode_e mode_r, mode_nxt;
   logic initReq_r, sleepReq_r, autoWake_r;
   logic silent_r, loop_r, wakeIe_r, wakeFlag_r;
   logic rxMeta_r, rxSync_r;
   logic [7:0] rdData_r;
   logic txPin_r, coreRx_r, active_r, ignAck_r, txAllow_r, clkRun_r;
   logic wakeIrq_r;
   logic idle, idleClr, rxEff, txEff, busAct, hwWake;
   logic wrCtrl, wrDiag, wrIrqEn, wrStat;
   logic [7:0] ctrlVal, statVal, diagVal, irqEnVal, rdMux;
   logic initAck, slpAck;
   logic wakeSync_r, wakeSync_nxt;

   // Receive pin is synchronised before anything looks at it.
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         rxMeta_r <= 1'b1;
         rxSync_r <= 1'b1;
      end else if (clkEn) begin
         rxMeta_r <= bus_rx_pin;
         rxSync_r <= rxMeta_r;
      end
   end

   assign wrCtrl = regWr && (regAddr == ADDR_CTRL);
   assign wrDiag = regWr && (regAddr == ADDR_DIAG);
   assign wrIrqEn = regWr && (regAddr == ADDR_IRQEN);
   assign wrStat = regWr && (regAddr == ADDR_STAT);

   // Sleep activity: dominant level on the synchronised pin. [RL23]
   assign busAct = (mode_r == CMC_SLEEP) && !rxSync_r;
   // Automatic wake-up clears the sleep request itself. [RL12]
   assign hwWake = busAct && autoWake_r;

   // Control register; entering a mode never touches configuration. [RL7]
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         initReq_r <= CTRL_RST[CTRL_INIT];
         sleepReq_r <= CTRL_RST[CTRL_SLEEP];
         autoWake_r <= CTRL_RST[CTRL_AWAKE];
      end else if (clkEn) begin
         if (wrCtrl) begin
            initReq_r <= regWrData[CTRL_INIT];
            autoWake_r <= regWrData[CTRL_AWAKE];
         end
         if (hwWake) begin
            sleepReq_r <= 1'b0; // [RL12]
         end else if (wrCtrl) begin
            sleepReq_r <= regWrData[CTRL_SLEEP]; // [RL12]
         end
      end
   end

   // Test bits can be written only in Initialization. [RL16]
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         silent_r <= DIAG_RST[DIAG_SILENT];
         loop_r <= DIAG_RST[DIAG_LOOP];
         wakeIe_r <= IRQEN_RST[IRQEN_WAKE];
      end else if (clkEn) begin
         if (wrDiag && mode_r == CMC_INIT) begin
            silent_r <= regWrData[DIAG_SILENT];
            loop_r <= regWrData[DIAG_LOOP];
         end
         if (wrIrqEn) begin
            wakeIe_r <= regWrData[IRQEN_WAKE];
         end
      end
   end

   // Wake-up flag: set beats a write-one-to-clear. [RL14]
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         wakeFlag_r <= 1'b0;
      end else if (clkEn) begin
         if (busAct) begin
            wakeFlag_r <= 1'b1;
         end else if (wrStat && regWrData[STAT_WAKE]) begin
            wakeFlag_r <= 1'b0;
         end
      end
   end

   // Mode sequencing.
   always_comb begin
      mode_nxt = mode_r;
      case (mode_r)
         CMC_SLEEP: begin
            // Init requests during Sleep are not acknowledged. [RL11]
            if (!sleepReq_r && !hwWake) begin
               mode_nxt = CMC_SYNC; // [RL15]
            end
         end
         CMC_INIT: begin
            if (sleepReq_r) begin
               mode_nxt = CMC_SLEEP;
            end else if (!initReq_r) begin
               mode_nxt = CMC_SYNC; // [RL5]
            end
         end
         CMC_SYNC: begin
            if (initReq_r) begin
               mode_nxt = CMC_INIT;
            end else if (sleepReq_r) begin
               mode_nxt = CMC_SLEEP;
            end else if (idle) begin
               mode_nxt = CMC_NORMAL; // [RL4]
            end
         end
         CMC_NORMAL: begin
            if (initReq_r) begin
               mode_nxt = CMC_INIT;
            end else if (sleepReq_r) begin
               mode_nxt = CMC_SLEEP;
            end
         end
         default: mode_nxt = CMC_SLEEP;
      endcase
   end

   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         mode_r <= CMC_SLEEP; // [RL1]
      end else if (clkEn) begin
         mode_r <= mode_nxt;
      end
   end

   // Marks a synchronisation that began in Sleep, so the low-power
   // acknowledge holds until the bus has been seen idle. [RL15]
   assign wakeSync_nxt = (mode_nxt == CMC_SYNC) &&
                         ((mode_r == CMC_SLEEP) || wakeSync_r);

   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         wakeSync_r <= 1'b0;
      end else if (clkEn) begin
         wakeSync_r <= wakeSync_nxt; // [RL15]
      end
   end

   // Idle detection watches the effective receive line.
   assign idleClr = (mode_r != CMC_SYNC);
   cmc_idle_det #(
      .IDLE_BITS(IDLE_BITS)
   ) uIdle (
      .core_clk(core_clk),
      .reset(reset),
      .clkEn(clkEn),
      .bitTick(bitTick),
      .rxBit(rxEff),
      .clear(idleClr),
      .idle(idle)
   );

   // Acks follow the entered mode, so Normal means both clear. [RL2] [RL3]
   assign initAck = (mode_r == CMC_INIT);
   // Low-power ack stays set through synchronisation after wake. [RL15]
   assign slpAck = (mode_r == CMC_SLEEP) ||
                   ((mode_r == CMC_SYNC) && wakeSync_r);

   // Silent forbids driving and starting; loop back ignores the pin.
   assign txEff = (mode_r == CMC_NORMAL) ? coreTx : 1'b1; // [RL6]
   // Loop back feeds the core its own bit; silent ANDs its own bit with the pin. [RL18] [RL21] [RL22]
   assign rxEff = loop_r ? txEff :
                  (silent_r ? (rxSync_r & txEff) : rxSync_r);

   assign ctrlVal = {5'h00, autoWake_r, sleepReq_r, initReq_r};
   assign statVal = {4'h0, (mode_r == CMC_NORMAL), wakeFlag_r, slpAck,
                     initAck};
   assign diagVal = {6'h00, loop_r, silent_r};
   assign irqEnVal = {7'h00, wakeIe_r};
   assign rdMux = (regAddr == ADDR_CTRL) ? ctrlVal :
                  (regAddr == ADDR_STAT) ? statVal :
                  (regAddr == ADDR_DIAG) ? diagVal :
                  (regAddr == ADDR_IRQEN) ? irqEnVal : 8'h00;

   // Registered outputs.
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         rdData_r <= 8'h00;
         txPin_r <= 1'b1;
         coreRx_r <= 1'b1;
         active_r <= 1'b0;
         ignAck_r <= 1'b0;
         txAllow_r <= 1'b0;
         clkRun_r <= 1'b0;
         wakeIrq_r <= 1'b0;
      end else if (clkEn) begin
         rdData_r <= regRd ? rdMux : 8'h00;
         // Silent keeps the bus recessive. [RL6] [RL17] [RL22]
         txPin_r <= silent_r ? 1'b1 : txEff;
         coreRx_r <= rxEff; // [RL19] [RL21]
         active_r <= (mode_r == CMC_NORMAL); // [RL4] [RL6]
         ignAck_r <= loop_r; // [RL20]
         txAllow_r <= (mode_r == CMC_NORMAL) && !silent_r; // [RL17]
         // Core clock gate is off in Sleep, freezing status. [RL10]
         clkRun_r <= (mode_r != CMC_SLEEP);
         wakeIrq_r <= wakeFlag_r && wakeIe_r; // [RL14]
      end
   end

   assign regRdData = rdData_r;
   assign bus_tx_pin = txPin_r;
   assign coreRx = coreRx_r;
   assign coreActive = active_r;
   assign coreIgnoreAckErr = ignAck_r;
   assign coreTxAllowed = txAllow_r;
   assign coreClkRun = clkRun_r;
   assign wakeIrq = wakeIrq_r;

   chk_reset_sleep: assert property (@(posedge core_clk) // [RL1]
      $fell(reset) |-> mode_r == CMC_SLEEP)
      else $error("not in sleep after reset");
   chk_normal_acks: assert property (@(posedge core_clk) disable iff (reset)
      ((mode_r == CMC_NORMAL) || ((mode_r == CMC_SYNC) && !wakeSync_r)) ==
      (!initAck && !slpAck)) // [RL3]
      else $error("normal mode disagrees with acks");
   chk_wake_slpack: assert property (@(posedge core_clk) // [RL15]
      disable iff (reset)
      clkEn && mode_r == CMC_SLEEP && mode_nxt == CMC_SYNC |=> slpAck)
      else $error("low power ack dropped before sync");
   chk_init_config: assert property (@(posedge core_clk) // [RL7]
      disable iff (reset)
      clkEn && mode_r != CMC_INIT && mode_nxt == CMC_INIT && !wrDiag &&
      !wrIrqEn |=> $stable({loop_r, silent_r, wakeIe_r}))
      else $error("init entry changed configuration");
   chk_combined_rx: assert property (@(posedge core_clk) // [RL22]
      disable iff (reset)
      clkEn && loop_r && silent_r |=> bus_tx_pin && coreRx == $past(txEff))
      else $error("combined mode routing wrong");
   chk_loop_ackerr: assert property (@(posedge core_clk) // [RL20]
      disable iff (reset)
      clkEn |=> coreIgnoreAckErr == $past(loop_r))
      else $error("ack error ignore not loop back");
   chk_sync_idle: assert property (@(posedge core_clk) disable iff (reset)
      (mode_r == CMC_SYNC && clkEn && mode_nxt == CMC_NORMAL) |-> idle)
      // [RL4]
      else $error("normal entered without idle");
   chk_init_recessive: assert property (@(posedge core_clk)
      disable iff (reset) clkEn && mode_r == CMC_INIT |=> bus_tx_pin)
      // [RL6]
      else $error("tx not recessive in init");
   chk_sleep_noinit: assert property (@(posedge core_clk)
      disable iff (reset) mode_r == CMC_SLEEP |-> !initAck) // [RL11]
      else $error("init acked in sleep");
   chk_auto_wake: assert property (@(posedge core_clk) disable iff (reset)
      clkEn && busAct && autoWake_r |=> !sleepReq_r) // [RL12]
      else $error("auto wake did not clear sleep");
   chk_silent_tx: assert property (@(posedge core_clk) disable iff (reset)
      clkEn && silent_r |=> bus_tx_pin && !coreTxAllowed) // [RL17]
      else $error("silent mode drove bus");
   chk_loop_rx: assert property (@(posedge core_clk) disable iff (reset)
      clkEn && loop_r |=> coreRx == $past(txEff)) // [RL21]
      else $error("loop back not fed from tx");
   chk_wake_irq: assert property (@(posedge core_clk) disable iff (reset)
      clkEn && busAct && wakeIe_r ##1 clkEn && wakeIe_r |=> wakeIrq)
      // [RL14]
      else $error("wake irq missing");
   cov_normal: cover property (@(posedge core_clk)
      mode_r == CMC_SYNC ##1 mode_r == CMC_NORMAL);
   cov_auto_wake: cover property (@(posedge core_clk) hwWake);
   cov_init: cover property (@(posedge core_clk) mode_r == CMC_INIT);
   cov_wake_sync: cover property (@(posedge core_clk)
      mode_r == CMC_SYNC && wakeSync_r);
   cov_combined: cover property (@(posedge core_clk)
      loop_r && silent_r && mode_r == CMC_NORMAL);
endmodule

// ### cmc_bus_node.sv
// Behavioural model of the bus seen through the transceiver.
`timescale 1ns/1ps
module cmc_bus_node (
   // Levels that the nodes drive.
   input wire logic busTx,
   input wire logic otherDom,
   // Level at the receive pin.
   output logic busRx
);
   // Any dominant node wins; the pull-up makes an idle bus recessive.
   assign busRx = busTx & ~otherDom;
endmodule

// ### can_mode_control_tb.sv
// Self-checking testbench for the CAN operating-mode controller.
`timescale 1ns/1ps
module can_mode_control_tb;
   import cmc_pkg::*;
   logic core_clk, reset, clkEn, regWr, regRd, bitTick, coreTx;
   logic coreTxStart, othDom, busRx, coreRx, coreActive;
   logic coreIgnoreAckErr, coreTxAllowed, coreClkRun, bus_tx_pin, wakeIrq;
   logic [7:0] regAddr, regWrData, regRdData, rd;
   logic [1:0] tickCnt;
   int fails, compares;
   cmc_mode_ctrl uut (.core_clk(core_clk), .reset(reset), .clkEn(clkEn),
      .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr),
      .regRd(regRd), .regRdData(regRdData), .bitTick(bitTick),
      .coreTx(coreTx), .coreTxStart(coreTxStart), .coreRx(coreRx),
      .coreActive(coreActive), .coreIgnoreAckErr(coreIgnoreAckErr),
      .coreTxAllowed(coreTxAllowed), .coreClkRun(coreClkRun),
      .bus_rx_pin(busRx), .bus_tx_pin(bus_tx_pin), .wakeIrq(wakeIrq));
   cmc_bus_node node (.busTx(bus_tx_pin), .otherDom(othDom), .busRx(busRx));
   initial begin
      core_clk = 1'b0;
      forever #20 core_clk = ~core_clk;
   end
   // One bit time every four clocks.
   always @(posedge core_clk) begin
      if (reset) begin
         tickCnt <= 2'h0;
         bitTick <= 1'b0;
      end else begin
         tickCnt <= tickCnt + 2'h1;
         bitTick <= (tickCnt == 2'h3);
      end
   end
   task automatic conclude();
      $display("compares=%0d fails=%0d", compares, fails);
      if (fails == 0 && compares > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      compares++;
      if (seen !== exp) begin
         fails++;
         $display("unexpected at %0t: saw %h wanted %h", $time, seen, exp);
      end
   endtask
   task automatic idle(input int n);
      repeat (n) @(posedge core_clk);
   endtask
   task automatic wrReg(input logic [7:0] a, input logic [7:0] d);
      @(posedge core_clk);
      regAddr <= a;
      regWrData <= d;
      regWr <= 1'b1;
      @(posedge core_clk);
      regWr <= 1'b0;
   endtask
   task automatic rdReg(input logic [7:0] a);
      @(posedge core_clk);
      regAddr <= a;
      regRd <= 1'b1;
      @(posedge core_clk);
      regRd <= 1'b0;
      #1;
      rd = regRdData;
   endtask
   // Expected {transmit pin, core receive} for a test mode and bus state.
   function automatic logic [1:0] expRoute(input logic [1:0] dg,
         input logic tx, input logic oth);
      logic bt;
      logic pin;
      bt = dg[0] ? 1'b1 : tx;
      pin = bt & ~oth;
      return {bt, dg[1] ? tx : (dg[0] ? pin & tx : pin)};
   endfunction
   initial begin
      idle(20000);
      fails++;
      conclude();
   end
   initial begin
      logic [1:0] e;
      reset = 1'b1;
      clkEn = 1'b1;
      regAddr = 8'h00;
      regWrData = 8'h00;
      regWr = 1'b0;
      regRd = 1'b0;
      coreTx = 1'b1;
      coreTxStart = 1'b0;
      othDom = 1'b0;
      void'($urandom(32'h3485));
      idle(20);
      reset <= 1'b0;
      check(8'({coreClkRun, bus_tx_pin, coreActive}), 8'h02);
      rdReg(ADDR_CTRL);
      check(rd, CTRL_RST);
      rdReg(ADDR_STAT);
      check(rd, 8'h02);
      wrReg(ADDR_CTRL, 8'h03);
      idle(8);
      rdReg(ADDR_STAT);
      check(rd, 8'h02);
      wrReg(8'h07, 8'hff);
      rdReg(8'h07);
      check(rd, 8'h00);
      wrReg(ADDR_CTRL, 8'h01);
      idle(60);
      rdReg(ADDR_STAT);
      check(rd, 8'h01);
      coreTx <= 1'b0;
      idle(4);
      check(8'({bus_tx_pin, coreTxAllowed}), 8'h02);
      coreTx <= 1'b1;
      // Test bits are written in Initialization; a write in Normal must leave them unchanged.
      // Filter banks are never activated by this bench.
      for (int m = 0; m < 4; m++) begin
         wrReg(ADDR_DIAG, 8'(m));
         rdReg(ADDR_DIAG);
         check(rd, 8'(m));
         wrReg(ADDR_CTRL, 8'h00);
         idle(30);
         check(8'(coreActive), 8'h00);
         idle(30);
         rdReg(ADDR_STAT);
         check(rd, 8'h08);
         check(8'(coreActive), 8'h01);
         check(8'(coreIgnoreAckErr), 8'(m >> 1));
         check(8'(coreTxAllowed), 8'(!m[0]));
         repeat (6) begin
            coreTx <= 1'($urandom);
            othDom <= 1'($urandom);
            coreTxStart <= 1'($urandom);
            idle(5);
            e = expRoute(2'(m), coreTx, othDom);
            check(8'({bus_tx_pin, coreRx}), 8'(e));
         end
         coreTx <= 1'b1;
         othDom <= 1'b0;
         wrReg(ADDR_DIAG, 8'h00);
         wrReg(ADDR_CTRL, 8'h01);
         idle(8);
         rdReg(ADDR_STAT);
         check(rd, 8'h01);
         rdReg(ADDR_DIAG);
         check(rd, 8'(m));
      end
      wrReg(ADDR_IRQEN, 8'h01);
      wrReg(ADDR_CTRL, 8'h06);
      idle(8);
      rdReg(ADDR_STAT);
      check(rd, 8'h02);
      check(8'(coreClkRun), 8'h00);
      othDom <= 1'b1;
      idle(6);
      check(8'(wakeIrq), 8'h01);
      rdReg(ADDR_CTRL);
      check(rd, 8'h04);
      othDom <= 1'b0;
      idle(60);
      rdReg(ADDR_STAT);
      check(rd, 8'h0c);
      wrReg(ADDR_STAT, 8'h04);
      idle(2);
      check(8'(wakeIrq), 8'h00);
      wrReg(ADDR_CTRL, 8'h02);
      idle(8);
      othDom <= 1'b1;
      idle(6);
      check(8'(wakeIrq), 8'h01);
      wrReg(ADDR_IRQEN, 8'h00);
      idle(2);
      check(8'(wakeIrq), 8'h00);
      othDom <= 1'b0;
      idle(60);
      rdReg(ADDR_STAT);
      check(rd, 8'h06);
      wrReg(ADDR_CTRL, 8'h00);
      rdReg(ADDR_STAT);
      check(rd, 8'h06);
      idle(60);
      rdReg(ADDR_STAT);
      check(rd, 8'h0c);
      clkEn <= 1'b0;
      wrReg(ADDR_CTRL, 8'h01);
      clkEn <= 1'b1;
      rdReg(ADDR_CTRL);
      check(rd, 8'h00);
      conclude();
   end
endmodule
